// >>> src/tsr_pkg.sv
//------------------------------------------------------------
// shared constants of the limit / user-word register bank
//------------------------------------------------------------
package tsr_pkg;

    //--------------------------------------------------------
    // widths
    //--------------------------------------------------------
    localparam int DATA_W    = 32;   // avalon data width
    localparam int REG_W     = 16;   // width of every register
    localparam int ADDR_W    = 6;    // byte address, 16 words
    localparam int IDX_W     = 4;    // register index width
    localparam int LIMIT_W   = 14;   // threshold field width
    localparam int LIMIT_LSB = 2;    // threshold field position
    localparam int NV_WORDS  = 8;    // number of user words
    localparam int BE_W      = 4;    // byte enables per word
    localparam int UNLOCK_BIT = 0;   // position in temp result

    //--------------------------------------------------------
    // register indices (byte address is four times these)
    //--------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_ALERT1_LOW  = 4'h3;
    localparam logic [IDX_W-1:0] IDX_ALERT2_HIGH = 4'h4;
    localparam logic [IDX_W-1:0] IDX_ALERT2_LOW  = 4'h5;
    localparam logic [IDX_W-1:0] IDX_NV_FIRST    = 4'h6;
    localparam logic [IDX_W-1:0] IDX_NV_LAST     = 4'hd;
    localparam logic [IDX_W-1:0] IDX_DIE_IDENTIFICATION      = 4'hf;

    //--------------------------------------------------------
    // reset values
    //--------------------------------------------------------
    localparam logic [LIMIT_W-1:0] RST_ALERT1_LOW  = 14'h2000;
    localparam logic [LIMIT_W-1:0] RST_ALERT2_HIGH = 14'h1fff;
    localparam logic [LIMIT_W-1:0] RST_ALERT2_LOW  = 14'h2000;
    localparam logic [REG_W-1:0]   RST_NV_WORD     = 16'h0000;

    // whole-register images after reset
    localparam logic [REG_W-1:0] IMG_ALERT1_LOW  = 16'h8000;
    localparam logic [REG_W-1:0] IMG_ALERT2_HIGH = 16'h7ffc;
    localparam logic [REG_W-1:0] IMG_ALERT2_LOW  = 16'h8000;

    // value is arbitrary, stands in for the die code
    localparam logic [REG_W-1:0] DIE_IDENTIFICATION_DEFAULT  = 16'h5a3c;

    //--------------------------------------------------------
    // bus handshake states
    //--------------------------------------------------------
    typedef enum logic {
        TSR_IDLE,
        TSR_ANSWER
    } tsr_bus_st_t;

endpackage

// >>> src/tsr_limit_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tsr_limit_regs #(
    parameter logic [15:0] DIE_IDENTIFICATION = tsr_pkg::DIE_IDENTIFICATION_DEFAULT
) (
    input  wire logic                          CORE_CLK_I,
    input  wire logic                          SYS_RST_I,
    input  wire logic                          CE_I,
    input  wire logic [tsr_pkg::ADDR_W-1:0]    AVS_ADDRESS_I,
    input  wire logic                          AVS_READ_I,
    input  wire logic                          AVS_WRITE_I,
    input  wire logic [tsr_pkg::DATA_W-1:0]    AVS_WRITEDATA_I,
    input  wire logic [tsr_pkg::BE_W-1:0]      AVS_BYTEENABLE_I,
    output logic      [tsr_pkg::DATA_W-1:0]    AVS_READDATA_O,
    output logic                               AVS_WAITREQUEST_O,
    input  wire logic [tsr_pkg::REG_W-1:0]     TEMP_RESULT_I,
    output logic      [tsr_pkg::LIMIT_W-1:0]   ALERT1_LOW_O,
    output logic      [tsr_pkg::LIMIT_W-1:0]   ALERT2_HIGH_O,
    output logic      [tsr_pkg::LIMIT_W-1:0]   ALERT2_LOW_O
);
    import tsr_pkg::*;

    //--------------------------------------------------------
    // state
    //--------------------------------------------------------
    typedef struct packed {
        tsr_bus_st_t                           bus;
        logic [DATA_W-1:0]                     rdata;
        logic [LIMIT_W-1:0]                    alert1_low;
        logic [LIMIT_W-1:0]                    alert2_high;
        logic [LIMIT_W-1:0]                    alert2_low;
        logic [NV_WORDS-1:0][REG_W-1:0]        nv;
    } tsr_state_t;

    localparam tsr_state_t RST_STATE = '{
        bus:         TSR_IDLE,
        rdata:       '0,
        alert1_low:  RST_ALERT1_LOW,
        alert2_high: RST_ALERT2_HIGH,
        alert2_low:  RST_ALERT2_LOW,
        nv:          {NV_WORDS{RST_NV_WORD}}
    };

    tsr_state_t                    st_reg;
    tsr_state_t                    st_next;
    logic [IDX_W-1:0]              idx;
    logic                          req;
    logic                          write_go;
    logic                          unlock;
    logic [REG_W-1:0]              rd_word;
    logic [NV_WORDS-1:0][REG_W-1:0] nv_next;

    //--------------------------------------------------------
    // helpers
    //--------------------------------------------------------
    // merge the two low byte lanes into a 16-bit register
    function automatic logic [REG_W-1:0] merge16(
        input logic [REG_W-1:0]  old,
        input logic [DATA_W-1:0] wd,
        input logic [BE_W-1:0]   be
    );
        logic [REG_W-1:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // lanes 2 and 3 carry nothing: the upper half reads zero
    assign idx      = AVS_ADDRESS_I[ADDR_W-1:2];
    assign req      = AVS_READ_I | AVS_WRITE_I;
    assign write_go = (st_reg.bus == TSR_ANSWER) & AVS_WRITE_I;
    assign unlock   = TEMP_RESULT_I[UNLOCK_BIT];

    //--------------------------------------------------------
    // read multiplexer
    //--------------------------------------------------------
    // unmapped indices (0h-2h, Eh) answer zero
    always_comb begin
        rd_word = '0;
        case (idx)
            IDX_ALERT1_LOW:  rd_word = {st_reg.alert1_low, 2'b00};
            IDX_ALERT2_HIGH: rd_word = {st_reg.alert2_high, 2'b00};
            IDX_ALERT2_LOW:  rd_word = {st_reg.alert2_low, 2'b00};
            IDX_DIE_IDENTIFICATION:      rd_word = DIE_IDENTIFICATION;
            default: begin
                if (idx >= IDX_NV_FIRST && idx <= IDX_NV_LAST) begin
                    rd_word = st_reg.nv[3'(idx - IDX_NV_FIRST)];
                end
            end
        endcase
    end

    //--------------------------------------------------------
    // user word write gating, one slice per word
    //--------------------------------------------------------
    // the host gets no sign of a dropped write; it must read back
    genvar gi;
    generate
        for (gi = 0; gi < NV_WORDS; gi++) begin : g_nv
            logic hit;
            assign hit = (idx == 4'(IDX_NV_FIRST + gi));
            assign nv_next[gi] = (write_go && hit && unlock)
                               ? merge16(st_reg.nv[gi], AVS_WRITEDATA_I, AVS_BYTEENABLE_I)
                               : st_reg.nv[gi];
        end
    endgenerate

    //--------------------------------------------------------
    // next state
    //--------------------------------------------------------
    // one wait cycle lets the read mux settle into a flop
    always_comb begin
        logic [REG_W-1:0] m;
        m = '0;
        st_next = st_reg;
        st_next.nv = nv_next;
        case (st_reg.bus)
            TSR_IDLE: begin
                if (req) begin
                    st_next.bus = TSR_ANSWER;
                    if (AVS_READ_I) begin
                        st_next.rdata = {16'h0000, rd_word};
                    end
                end
            end
            TSR_ANSWER: begin
                st_next.bus = TSR_IDLE;
                if (write_go) begin
                    case (idx)
                        IDX_ALERT1_LOW: begin
                            m = merge16({st_reg.alert1_low, 2'b00},
                                        AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                            st_next.alert1_low = m[15:2];
                        end
                        IDX_ALERT2_HIGH: begin
                            m = merge16({st_reg.alert2_high, 2'b00},
                                        AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                            st_next.alert2_high = m[15:2];
                        end
                        IDX_ALERT2_LOW: begin
                            m = merge16({st_reg.alert2_low, 2'b00},
                                        AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
                            st_next.alert2_low = m[15:2];
                        end
                        // die_identification and unmapped words keep no write
                        default: begin
                            m = '0;
                        end
                    endcase
                end
            end
            default: begin
                st_next.bus = TSR_IDLE;
            end
        endcase
    end

    //--------------------------------------------------------
    // state register
    //--------------------------------------------------------
    // reset acts even with the enable low, so a frozen core still resets
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            st_reg <= RST_STATE;
        end else if (CE_I) begin
            st_reg <= st_next;
        end
    end

    //--------------------------------------------------------
    // outputs
    //--------------------------------------------------------
    // waitrequest stays high while frozen, so no write is lost
    assign AVS_WAITREQUEST_O = !((st_reg.bus == TSR_ANSWER) && CE_I);
    assign AVS_READDATA_O    = st_reg.rdata;
    assign ALERT1_LOW_O      = st_reg.alert1_low;
    assign ALERT2_HIGH_O     = st_reg.alert2_high;
    assign ALERT2_LOW_O      = st_reg.alert2_low;

    //--------------------------------------------------------
    // assertions
    //--------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SYS_RST_I || !CE_I);

    logic ans;
    logic full_be;
    assign ans     = (st_reg.bus == TSR_ANSWER);
    assign full_be = (AVS_BYTEENABLE_I[1:0] == 2'b11);

    // reset images checked the cycle after reset, enable or not
    reset_images_a: assert property (
        disable iff (1'b0)
        $past(SYS_RST_I) |-> ({ALERT1_LOW_O, 2'b00} == IMG_ALERT1_LOW)
            && ({ALERT2_HIGH_O, 2'b00} == IMG_ALERT2_HIGH)
            && ({ALERT2_LOW_O, 2'b00} == IMG_ALERT2_LOW))
        else $error("threshold reset image wrong");

    nv_reset_zero_a: assert property (
        disable iff (1'b0)
        $past(SYS_RST_I) |-> (st_reg.nv == '0))
        else $error("user words not zero after reset");

    one_wait_a: assert property (
        (req && !ans) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("answer not one cycle after request");

    low_bits_zero_a: assert property (
        (ans && AVS_READ_I && idx >= IDX_ALERT1_LOW && idx <= IDX_ALERT2_LOW)
        |-> (AVS_READDATA_O[1:0] == 2'b00)
            && (AVS_READDATA_O[31:16] == 16'h0000))
        else $error("reserved threshold bits not zero");

    high2_write_a: assert property (
        (ans && AVS_WRITE_I && full_be && idx == IDX_ALERT2_HIGH)
        |=> ALERT2_HIGH_O == $past(AVS_WRITEDATA_I[15:2]))
        else $error("alert2 high write lost");

    low2_write_a: assert property (
        (ans && AVS_WRITE_I && full_be && idx == IDX_ALERT2_LOW)
        |=> ALERT2_LOW_O == $past(AVS_WRITEDATA_I[15:2]))
        else $error("alert2 low write lost");

    low1_write_a: assert property (
        (ans && AVS_WRITE_I && full_be && idx == IDX_ALERT1_LOW)
        |=> ALERT1_LOW_O == $past(AVS_WRITEDATA_I[15:2]))
        else $error("alert1 low write lost");

    nv_unlocked_a: assert property (
        (ans && AVS_WRITE_I && full_be && unlock && idx == IDX_NV_FIRST)
        |=> st_reg.nv[0] == $past(AVS_WRITEDATA_I[15:0]))
        else $error("unlocked user word write lost");

    nv_locked_a: assert property (
        (ans && AVS_WRITE_I && !unlock) |=> $stable(st_reg.nv))
        else $error("locked user word changed");

    die_identification_read_a: assert property (
        (ans && AVS_READ_I && idx == IDX_DIE_IDENTIFICATION)
        |-> AVS_READDATA_O == {16'h0000, DIE_IDENTIFICATION})
        else $error("die_identification read wrong");

    quiet_hold_a: assert property (
        !write_go |=> $stable(ALERT1_LOW_O) && $stable(ALERT2_HIGH_O)
            && $stable(ALERT2_LOW_O) && $stable(st_reg.nv))
        else $error("register changed without a write");

    nv_readback_a: assert property (
        (ans && AVS_READ_I && idx == IDX_NV_LAST)
        |-> AVS_READDATA_O == {16'h0000, st_reg.nv[NV_WORDS-1]})
        else $error("user word read-back mismatch");

    //--------------------------------------------------------
    // read mapping and write isolation
    //--------------------------------------------------------
    // each threshold must come back at its own index
    alert1_read_a: assert property (
        (ans && AVS_READ_I && idx == IDX_ALERT1_LOW)
        |-> AVS_READDATA_O == {16'h0000, ALERT1_LOW_O, 2'b00})
        else $error("alert1 low read wrong");

    alert2h_read_a: assert property (
        (ans && AVS_READ_I && idx == IDX_ALERT2_HIGH)
        |-> AVS_READDATA_O == {16'h0000, ALERT2_HIGH_O, 2'b00})
        else $error("alert2 high read wrong");

    alert2l_read_a: assert property (
        (ans && AVS_READ_I && idx == IDX_ALERT2_LOW)
        |-> AVS_READDATA_O == {16'h0000, ALERT2_LOW_O, 2'b00})
        else $error("alert2 low read wrong");

    // a write to the id word must leave every register alone
    die_identification_hold_a: assert property (
        (ans && AVS_WRITE_I && idx == IDX_DIE_IDENTIFICATION)
        |=> $stable(ALERT1_LOW_O) && $stable(ALERT2_HIGH_O)
            && $stable(ALERT2_LOW_O) && $stable(st_reg.nv)
            && $stable(AVS_READDATA_O))
        else $error("die_identification write changed state");

    hole_write_a: assert property (
        (ans && AVS_WRITE_I
            && (idx < IDX_ALERT1_LOW || idx == IDX_NV_LAST + 4'h1))
        |=> $stable(ALERT1_LOW_O) && $stable(ALERT2_HIGH_O)
            && $stable(ALERT2_LOW_O) && $stable(st_reg.nv))
        else $error("unmapped write changed state");

    hole_read_a: assert property (
        (ans && AVS_READ_I
            && (idx < IDX_ALERT1_LOW || idx == IDX_NV_LAST + 4'h1))
        |-> AVS_READDATA_O == '0)
        else $error("unmapped read not zero");

    // a user word write touches its own slice and lanes only
    nv_neighbor_a: assert property (
        (ans && AVS_WRITE_I && idx == IDX_NV_FIRST)
        |=> $stable(st_reg.nv[NV_WORDS-1:1]))
        else $error("user word write spilled over");

    nv_lane_a: assert property (
        (ans && AVS_WRITE_I && unlock && idx == IDX_NV_FIRST
            && AVS_BYTEENABLE_I[1:0] == 2'b01)
        |=> st_reg.nv[0] == {$past(st_reg.nv[0][15:8]), $past(AVS_WRITEDATA_I[7:0])})
        else $error("user word byte lane wrong");

    // reset leaves the bus idle and the read word cleared, enable or not
    reset_bus_a: assert property (
        disable iff (1'b0)
        $past(SYS_RST_I) |-> AVS_WAITREQUEST_O && (AVS_READDATA_O == '0))
        else $error("bus not idle after reset");

    // a low enable freezes everything, so the master must be held off
    ce_freeze_a: assert property (
        disable iff (1'b0)
        (!CE_I && !SYS_RST_I) |=> $stable(st_reg))
        else $error("state moved while enable low");

    frozen_wait_a: assert property (
        disable iff (SYS_RST_I)
        !CE_I |-> AVS_WAITREQUEST_O)
        else $error("waitrequest low while enable low");

    //--------------------------------------------------------
    // covers
    //--------------------------------------------------------
    nv_write_ok_c: cover property (
        ans && AVS_WRITE_I && unlock && idx == IDX_NV_FIRST + 4'h2);
    nv_write_drop_c: cover property (
        ans && AVS_WRITE_I && !unlock && idx == IDX_NV_LAST);
    die_read_c: cover property (ans && AVS_READ_I && idx == IDX_DIE_IDENTIFICATION);
    back_to_back_c: cover property (
        ans && AVS_WRITE_I ##2 !ans && AVS_READ_I ##1 ans);
    nv_partial_c: cover property (
        ans && AVS_WRITE_I && unlock && AVS_BYTEENABLE_I[1:0] == 2'b01);

endmodule

`default_nettype wire

// >>> tb/tsr_temp_source.sv
`timescale 1ns/1ps
`default_nettype none

//------------------------------------------------------------
// stand-in for the temperature result register on the far side
//------------------------------------------------------------
module tsr_temp_source (
    input  wire logic        clk_i,
    input  wire logic        unlock_i,
    output logic [15:0]      temp_result_o
);
    // reading bits keep moving so the bank cannot lean on them
    logic [14:0] temp_reg = 15'h1234;

    // free-running fake temperature, one step a cycle
    always_ff @(posedge clk_i) begin
        temp_reg <= temp_reg + 15'h0001;
    end

    // host raises the flag before programming user words
    assign temp_result_o = {temp_reg, unlock_i};
endmodule

`default_nettype wire

// >>> tb/temp_sensor_limit_eeprom_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_limit_eeprom_regs_bench;
    import tsr_pkg::*;

    // value is arbitrary, only needs to differ from the design default
    localparam logic [REG_W-1:0] TB_DIE_IDENTIFICATION = 16'hc3a5;

    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 ce = 1'b1;
    logic [ADDR_W-1:0]    addr = '0;
    logic                 rd = 1'b0;
    logic                 wr = 1'b0;
    logic [DATA_W-1:0]    wdata = '0;
    logic [BE_W-1:0]      be = 4'hf;
    logic [DATA_W-1:0]    rdata;
    logic                 waitreq;
    logic [REG_W-1:0]     temp;
    logic                 unlock = 1'b0;
    logic [LIMIT_W-1:0]   a1l;
    logic [LIMIT_W-1:0]   a2h;
    logic [LIMIT_W-1:0]   a2l;
    logic [DATA_W-1:0]    q;
    int                   n_mismatch = 0;
    int                   compares = 0;
    int                   cyc = 0;

    //--------------------------------------------------------
    // clock, enable pattern, timeout
    //--------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end

    // enable drops one cycle in seven so any wait that meets a low cycle gets stretched
    always @(posedge clk) begin
        cyc = cyc + 1;
        ce <= (cyc % 7 != 3);
        if (cyc == 3000) begin
            n_mismatch++;
            close_out();
        end
    end

    tsr_limit_regs #(.DIE_IDENTIFICATION(TB_DIE_IDENTIFICATION)) uut (
        .CORE_CLK_I        (clk),
        .SYS_RST_I         (rst),
        .CE_I              (ce),
        .AVS_ADDRESS_I     (addr),
        .AVS_READ_I        (rd),
        .AVS_WRITE_I       (wr),
        .AVS_WRITEDATA_I   (wdata),
        .AVS_BYTEENABLE_I  (be),
        .AVS_READDATA_O    (rdata),
        .AVS_WAITREQUEST_O (waitreq),
        .TEMP_RESULT_I     (temp),
        .ALERT1_LOW_O      (a1l),
        .ALERT2_HIGH_O     (a2h),
        .ALERT2_LOW_O      (a2l)
    );

    tsr_temp_source far_side (
        .clk_i         (clk),
        .unlock_i      (unlock),
        .temp_result_o (temp)
    );

    //--------------------------------------------------------
    // tasks
    //--------------------------------------------------------
    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one avalon cycle; entered and left just after a rising edge
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [REG_W-1:0] d, output logic [DATA_W-1:0] r);
        addr  <= a;
        wdata <= {16'hffff, d};
        wr    <= w;
        rd    <= !w;
        // only the bench timeout ends a wait that never answers
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask

    //--------------------------------------------------------
    // test sequence
    //--------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset images of the threshold registers and outputs
        bus(0, 6'h0c, 16'h0000, q); chk(q, 32'h8000);
        bus(0, 6'h10, 16'h0000, q); chk(q, 32'h7ffc);
        bus(0, 6'h14, 16'h0000, q); chk(q, 32'h8000);
        chk(32'(a1l), 32'h2000);
        chk(32'(a2h), 32'h1fff);
        chk(32'(a2l), 32'h2000);
        for (int i = 0; i < NV_WORDS; i++) begin
            bus(0, 6'(8'h18 + 4 * i), 16'h0000, q); chk(q, 32'h0);
        end
        bus(0, 6'h3c, 16'h0000, q); chk(q, 32'(TB_DIE_IDENTIFICATION));
        // low two bits of a threshold never stick
        bus(1, 6'h0c, 16'h5557, q);
        bus(0, 6'h0c, 16'h0000, q); chk(q, 32'h5554);
        chk(32'(a1l), 32'h1555);
        bus(1, 6'h10, 16'h8003, q);
        bus(0, 6'h10, 16'h0000, q); chk(q, 32'h8000);
        chk(32'(a2h), 32'h2000);
        bus(1, 6'h14, 16'h7ffe, q);
        bus(0, 6'h14, 16'h0000, q); chk(q, 32'h7ffc);
        chk(32'(a2l), 32'h1fff);
        // locked: every user word write must vanish
        for (int i = 0; i < NV_WORDS; i++) begin
            bus(1, 6'(8'h18 + 4 * i), 16'(16'ha5a0 + i), q);
        end
        for (int i = 0; i < NV_WORDS; i++) begin
            bus(0, 6'(8'h18 + 4 * i), 16'h0000, q); chk(q, 32'h0);
        end
        // unlocked: each word keeps its own value
        unlock <= 1'b1;
        for (int i = 0; i < NV_WORDS; i++) begin
            bus(1, 6'(8'h18 + 4 * i), 16'(16'h3c10 * (i + 1)), q);
        end
        for (int i = 0; i < NV_WORDS; i++) begin
            bus(0, 6'(8'h18 + 4 * i), 16'h0000, q);
            chk(q, 32'(16'(16'h3c10 * (i + 1))));
        end
        // only the enabled low lane lands in a user word
        be <= 4'h1;
        bus(1, 6'h18, 16'h12ff, q);
        be <= 4'hf;
        bus(0, 6'h18, 16'h0000, q); chk(q, 32'h3cff);
        // relocking protects the stored word again
        unlock <= 1'b0;
        bus(1, 6'h34, 16'hffff, q);
        bus(0, 6'h34, 16'h0000, q); chk(q, 32'(16'(16'h3c10 * 8)));
        // identification word ignores writes
        bus(1, 6'h3c, 16'h0000, q);
        bus(0, 6'h3c, 16'h0000, q); chk(q, 32'(TB_DIE_IDENTIFICATION));
        // unmapped places read zero, writes do nothing
        bus(1, 6'h38, 16'hffff, q);
        bus(0, 6'h38, 16'h0000, q); chk(q, 32'h0);
        bus(1, 6'h00, 16'hffff, q);
        bus(0, 6'h00, 16'h0000, q); chk(q, 32'h0);
        close_out();
    end
endmodule

`default_nettype wire
